// File: verilog/cfp_consts.svh
/*
  Constants of the fetch/execute pipeline core: reset values, opcode patterns,
  data address map figures. Assumes nothing; definitions only.
*/
`ifndef CFP_CONSTS_SVH
`define CFP_CONSTS_SVH

`define CFP_PC_W          21
`define CFP_DADDR_W       12
`define CFP_PC_STEP       21'h000002
`define CFP_PC_RESET      21'h000002
`define CFP_FETCH_RESET   21'h000000
`define CFP_NOP_WORD      16'h0000
`define CFP_SECOND_TAG    4'hf
`define CFP_OP_BANKLOAD   12'h010
`define CFP_OP_LITWORK    8'h0e
`define CFP_OP_MOVF       6'h14
`define CFP_OP_MOVWF      7'h37
`define CFP_OP_TSTSKIP    7'h33
`define CFP_OP_BRA        5'h1a
`define CFP_OP_GOTO       8'hef
`define CFP_OP_CALL       7'h76
`define CFP_OP_PTRLOAD    10'h3b8
`define CFP_OP_REGMOVE    4'hc
`define CFP_ACCESS_SPLIT  8'h60
`define CFP_ACCESS_LOBANK 4'h0
`define CFP_ACCESS_HIBANK 4'hf
`define CFP_IMPL_BANKS    16'hffff

`endif

// File: verilog/cfp_pkg.sv
/*
  Types shared by the pipeline core and its phase generator.
  Assumes the constants header is available for numeric values.
*/
package cfp_pkg;

  typedef enum logic [1:0] {
    CFP_PH_ONE,
    CFP_PH_TWO,
    CFP_PH_THREE,
    CFP_PH_FOUR
  } cfp_phase_t;

  typedef enum logic [3:0] {
    CFP_X_NOP,
    CFP_X_BANKLOAD,
    CFP_X_LITWORK,
    CFP_X_MOVF,
    CFP_X_MOVWF,
    CFP_X_TSTSKIP,
    CFP_X_BRA,
    CFP_X_GOTO,
    CFP_X_PTRLOAD,
    CFP_X_REGMOVE,
    CFP_X_SECOND
  } cfp_op_t;

endpackage

// File: verilog/cfp_phase_if.sv
/*
  Phase strobes from the phase generator to the core.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface cfp_phase_if;
  cfp_pkg::cfp_phase_t phase;
  logic                phase_one;
  logic                phase_two;
  logic                phase_three;
  logic                phase_four;

  modport gen
  (
    output phase,
    output phase_one,
    output phase_two,
    output phase_three,
    output phase_four
  );

  modport user
  (
    input phase,
    input phase_one,
    input phase_two,
    input phase_three,
    input phase_four
  );
endinterface

// File: verilog/cfp_phase_gen.sv
/*
  Divides the system clock into four non-overlapping phases, one clock each.
  Assumes a synchronous active-low reset on the same clock.
*/
`timescale 1ns/1ps

module cfp_phase_gen
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  cfp_phase_if.gen  ph
);

  cfp_pkg::cfp_phase_t phase_ff;
  cfp_pkg::cfp_phase_t nxt_phase;

  always_comb
  begin
    case (phase_ff)
      cfp_pkg::CFP_PH_ONE:   nxt_phase = cfp_pkg::CFP_PH_TWO;
      cfp_pkg::CFP_PH_TWO:   nxt_phase = cfp_pkg::CFP_PH_THREE;
      cfp_pkg::CFP_PH_THREE: nxt_phase = cfp_pkg::CFP_PH_FOUR;
      default:               nxt_phase = cfp_pkg::CFP_PH_ONE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      phase_ff <= cfp_pkg::CFP_PH_ONE;
    else
      phase_ff <= nxt_phase;
  end

  assign ph.phase       = phase_ff;
  assign ph.phase_one   = (phase_ff == cfp_pkg::CFP_PH_ONE);
  assign ph.phase_two   = (phase_ff == cfp_pkg::CFP_PH_TWO);
  assign ph.phase_three = (phase_ff == cfp_pkg::CFP_PH_THREE);
  assign ph.phase_four  = (phase_ff == cfp_pkg::CFP_PH_FOUR);

endmodule

// File: verilog/cfp_core.sv
/*
  Fetch/decode/execute pipeline of an 8-bit core with byte-addressed program
  memory and a banked 12-bit data space with a fast-access bank.
  Assumes program memory answers one clock after the fetch address changes and
  holds data until the end of phase three; data memory answers a read in the
  same clock as the read strobe. ALU, stack and interrupts live elsewhere.
*/
`timescale 1ns/1ps
`include "cfp_consts.svh"

module cfp_core
#(
  parameter logic [15:0] IMPL_BANKS = `CFP_IMPL_BANKS
)
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  output logic [3:0]       o_phase,
  output logic [20:0]      o_pmem_addr,
  output logic             o_pmem_rd,
  input  wire logic [15:0] i_pmem_data,
  output logic [11:0]      o_dmem_addr,
  output logic             o_dmem_rd,
  input  wire logic [7:0]  i_dmem_rdata,
  output logic             o_dmem_wr,
  output logic [7:0]       o_dmem_wdata,
  output logic [20:0]      o_pc,
  output logic [15:0]      o_instr_latch,
  output logic [7:0]       o_work,
  output logic [7:0]       o_bank_selector,
  output logic             o_flush
);

  cfp_phase_if ph ();

  cfp_phase_gen u_phase
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .ph       (ph)
  );

  logic [20:0]     pc_ff;
  logic [20:0]     fetch_pc_ff;
  logic [20:0]     pmem_addr_ff;
  logic [15:0]     fetch_word_ff;
  logic [15:0]     instr_latch_ff;
  logic [20:0]     instr_pc_ff;
  logic            pair_ok_ff;
  logic [15:0]     first_word_ff;
  logic [3:0]      bank_sel_ff;
  logic [7:0]      work_ff;
  logic [11:0]     dmem_addr_ff;
  logic            dmem_rd_ff;
  logic            dmem_wr_ff;
  logic [7:0]      dmem_wdata_ff;
  logic [7:0]      opnd_ff;
  logic            flush_ff;

  cfp_pkg::cfp_op_t exec_op;
  logic [11:0]     banked_addr;
  logic [11:0]     op_addr;
  logic            needs_read;
  logic            needs_write;
  logic            addr_impl;
  logic            jump_abs;
  logic            branch_rel;
  logic            skip_now;
  logic            kill;
  logic [20:0]     abs_target;
  logic [20:0]     rel_target;
  logic [20:0]     pc_sel;

  // second words decode as a no-operation unless their first word ran just before
  function automatic cfp_pkg::cfp_op_t decode(input logic [15:0] w, input logic pair_ok);
    cfp_pkg::cfp_op_t op;
    op = cfp_pkg::CFP_X_NOP;
    if (w[15:12] == `CFP_SECOND_TAG)
      op = pair_ok ? cfp_pkg::CFP_X_SECOND : cfp_pkg::CFP_X_NOP;
    else if (w[15:4] == `CFP_OP_BANKLOAD)
      op = cfp_pkg::CFP_X_BANKLOAD;
    else if (w[15:8] == `CFP_OP_LITWORK)
      op = cfp_pkg::CFP_X_LITWORK;
    else if (w[15:10] == `CFP_OP_MOVF)
      op = cfp_pkg::CFP_X_MOVF;
    else if (w[15:9] == `CFP_OP_MOVWF)
      op = cfp_pkg::CFP_X_MOVWF;
    else if (w[15:9] == `CFP_OP_TSTSKIP)
      op = cfp_pkg::CFP_X_TSTSKIP;
    else if (w[15:11] == `CFP_OP_BRA)
      op = cfp_pkg::CFP_X_BRA;
    else if (w[15:8] == `CFP_OP_GOTO || w[15:9] == `CFP_OP_CALL)
      op = cfp_pkg::CFP_X_GOTO;
    else if (w[15:6] == `CFP_OP_PTRLOAD)
      op = cfp_pkg::CFP_X_PTRLOAD;
    else if (w[15:12] == `CFP_OP_REGMOVE)
      op = cfp_pkg::CFP_X_REGMOVE;
    return op;
  endfunction

  assign exec_op = decode(instr_latch_ff, pair_ok_ff);

  // fast-access bank: addresses below 0x60 from bank 0, the rest from bank 15
  always_comb
  begin
    if (!instr_latch_ff[8])
    begin
      if (instr_latch_ff[7:0] < `CFP_ACCESS_SPLIT)
        banked_addr = {`CFP_ACCESS_LOBANK, instr_latch_ff[7:0]};
      else
        banked_addr = {`CFP_ACCESS_HIBANK, instr_latch_ff[7:0]};
    end
    else
      banked_addr = {bank_sel_ff, instr_latch_ff[7:0]};
  end

  // register-to-register move carries full 12-bit addresses and ignores the bank
  always_comb
  begin
    op_addr     = banked_addr;
    needs_read  = 1'b0;
    needs_write = 1'b0;
    case (exec_op)
      cfp_pkg::CFP_X_MOVF:
      begin
        needs_read  = 1'b1;
        needs_write = instr_latch_ff[9];
      end
      cfp_pkg::CFP_X_MOVWF:
        needs_write = 1'b1;
      cfp_pkg::CFP_X_TSTSKIP:
        needs_read = 1'b1;
      cfp_pkg::CFP_X_REGMOVE:
      begin
        op_addr    = instr_latch_ff[11:0];
        needs_read = 1'b1;
      end
      cfp_pkg::CFP_X_SECOND:
      begin
        op_addr     = instr_latch_ff[11:0];
        needs_write = (first_word_ff[15:12] == `CFP_OP_REGMOVE);
      end
      default:
      begin
        op_addr     = banked_addr;
        needs_read  = 1'b0;
        needs_write = 1'b0;
      end
    endcase
  end

  assign addr_impl = IMPL_BANKS[dmem_addr_ff[11:8]];

  // redirects: absolute target needs the second word, already in the fetch register
  assign jump_abs   = ph.phase_four && (exec_op == cfp_pkg::CFP_X_GOTO);
  assign branch_rel = ph.phase_four && (exec_op == cfp_pkg::CFP_X_BRA);
  assign skip_now   = ph.phase_four && (exec_op == cfp_pkg::CFP_X_TSTSKIP) && (opnd_ff == 8'h00);
  assign kill       = branch_rel || skip_now;
  assign abs_target = {fetch_word_ff[11:0], instr_latch_ff[7:0], 1'b0};
  assign rel_target = instr_pc_ff + `CFP_PC_STEP
                      + {{9{instr_latch_ff[10]}}, instr_latch_ff[10:0], 1'b0};

  always_comb
  begin
    if (jump_abs)
      pc_sel = abs_target;
    else if (branch_rel)
      pc_sel = rel_target;
    else
      pc_sel = pc_ff;
  end

  // program counter moves on the edge that opens phase one
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      pc_ff        <= `CFP_PC_RESET;
      fetch_pc_ff  <= `CFP_FETCH_RESET;
      pmem_addr_ff <= `CFP_FETCH_RESET;
    end
    else if (ph.phase_four)
    begin
      pmem_addr_ff <= {pc_sel[20:1], 1'b0};
      fetch_pc_ff  <= {pc_sel[20:1], 1'b0};
      pc_ff        <= {pc_sel[20:1], 1'b0} + `CFP_PC_STEP;
    end
  end

  // fetch of the next word runs beside the execution of the current one
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      fetch_word_ff <= `CFP_NOP_WORD;
    else if (ph.phase_three)
      fetch_word_ff <= i_pmem_data;
  end

  // a discarded word is replaced by a no-operation rather than suppressing the cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      instr_latch_ff <= `CFP_NOP_WORD;
      instr_pc_ff    <= `CFP_FETCH_RESET;
      pair_ok_ff     <= 1'b0;
      first_word_ff  <= `CFP_NOP_WORD;
      flush_ff       <= 1'b0;
    end
    else if (ph.phase_four)
    begin
      instr_latch_ff <= kill ? `CFP_NOP_WORD : fetch_word_ff;
      instr_pc_ff    <= fetch_pc_ff;
      first_word_ff  <= instr_latch_ff;
      flush_ff       <= kill;
      pair_ok_ff     <= !kill && (exec_op == cfp_pkg::CFP_X_GOTO
                                  || exec_op == cfp_pkg::CFP_X_PTRLOAD
                                  || exec_op == cfp_pkg::CFP_X_REGMOVE);
    end
  end

  // data read strobe stands through phase two, write strobe through phase four
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      dmem_addr_ff <= 12'h000;
      dmem_rd_ff   <= 1'b0;
    end
    else if (ph.phase_one)
    begin
      dmem_addr_ff <= op_addr;
      dmem_rd_ff   <= needs_read;
    end
    else
      dmem_rd_ff <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      opnd_ff <= 8'h00;
    else if (ph.phase_two && dmem_rd_ff)
      opnd_ff <= addr_impl ? i_dmem_rdata : 8'h00;
  end

  // writes to banks that are not there are dropped
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      dmem_wr_ff    <= 1'b0;
      dmem_wdata_ff <= 8'h00;
    end
    else if (ph.phase_three)
    begin
      dmem_wr_ff    <= needs_write && addr_impl;
      dmem_wdata_ff <= (exec_op == cfp_pkg::CFP_X_MOVWF) ? work_ff : opnd_ff;
    end
    else
      dmem_wr_ff <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      work_ff <= 8'h00;
    else if (ph.phase_four && exec_op == cfp_pkg::CFP_X_LITWORK)
      work_ff <= instr_latch_ff[7:0];
    else if (ph.phase_four && exec_op == cfp_pkg::CFP_X_MOVF && !instr_latch_ff[9])
      work_ff <= opnd_ff;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      bank_sel_ff <= 4'h0;
    else if (ph.phase_four && exec_op == cfp_pkg::CFP_X_BANKLOAD)
      bank_sel_ff <= instr_latch_ff[3:0];
  end

  assign o_phase         = {ph.phase_four, ph.phase_three, ph.phase_two, ph.phase_one};
  assign o_pmem_addr     = pmem_addr_ff;
  assign o_pmem_rd       = ph.phase_one;
  assign o_dmem_addr     = dmem_addr_ff;
  assign o_dmem_rd       = dmem_rd_ff;
  assign o_dmem_wr       = dmem_wr_ff;
  assign o_dmem_wdata    = dmem_wdata_ff;
  assign o_pc            = pc_ff;
  assign o_instr_latch   = instr_latch_ff;
  assign o_work          = work_ff;
  assign o_bank_selector = {4'h0, bank_sel_ff};
  assign o_flush         = flush_ff;

endmodule

// File: test/cfp_mem_model.sv
/*
  Program and data memory standing beside the pipeline core.
  Assumes the core's clock; the bench fills both arrays while the core is in reset.
*/
`timescale 1ns/1ps

module cfp_mem_model
(
  input  wire logic        i_clk,
  input  wire logic [20:0] i_pmem_addr,
  output logic [15:0]      o_pmem_data,
  input  wire logic [11:0] i_dmem_addr,
  input  wire logic        i_dmem_rd,
  output logic [7:0]       o_dmem_rdata,
  input  wire logic        i_dmem_wr,
  input  wire logic [7:0]  i_dmem_wdata
);
  logic [15:0] pmem [256];
  logic [7:0]  dmem [4096];

  // one clock behind the address; the low address bit is ignored
  always_ff @(posedge i_clk)
  begin
    o_pmem_data <= pmem[i_pmem_addr[8:1]];
  end

  // inverted data outside a read, so a late sample cannot pass by luck
  assign o_dmem_rdata = i_dmem_rd ? dmem[i_dmem_addr] : ~dmem[i_dmem_addr];

  always_ff @(posedge i_clk)
  begin
    if (i_dmem_wr)
    begin
      dmem[i_dmem_addr] <= i_dmem_wdata;
    end
  end
endmodule

// File: test/cfp_core_chk.sv
/*
  Port timing checks of the pipeline core.
  Assumes one clock and the core's synchronous active-low reset.
*/
`timescale 1ns/1ps

module cfp_core_chk
#(
  parameter logic [15:0] IMPL_BANKS = 16'hffff
)
(
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [3:0]  o_phase,
  input wire logic [20:0] o_pmem_addr,
  input wire logic        o_pmem_rd,
  input wire logic [11:0] o_dmem_addr,
  input wire logic        o_dmem_rd,
  input wire logic        o_dmem_wr,
  input wire logic [7:0]  o_dmem_wdata,
  input wire logic [20:0] o_pc,
  input wire logic [15:0] o_instr_latch,
  input wire logic [7:0]  o_work,
  input wire logic [7:0]  o_bank_selector,
  input wire logic        o_flush
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_phase_order: assert property (o_phase[0] |=> o_phase[1] ##1 o_phase[2] ##1 o_phase[3] ##1 o_phase[0])
    else $error("phase sequence broken");
  a_phase_onehot: assert property ($onehot(o_phase) && o_pmem_rd == o_phase[0])
    else $error("phase not one-hot");
  a_fetch_hold: assert property (!o_phase[0] |-> $stable(o_pmem_addr) && $stable(o_pc))
    else $error("fetch address moved outside phase one");
  a_even_addr: assert property (o_pmem_addr[0] == 1'b0 && o_pc[0] == 1'b0)
    else $error("odd program address");
  a_latch_hold: assert property (!o_phase[0] |-> $stable(o_instr_latch))
    else $error("instruction latch moved outside phase one");
  a_strobe_phase: assert property ((o_dmem_rd |-> o_phase[1]) and (o_dmem_wr |-> o_phase[3]))
    else $error("data strobe in wrong phase");
  a_daddr_hold: assert property (o_phase[2] || o_phase[3] |-> $stable(o_dmem_addr))
    else $error("data address moved during execute");
  a_access_map: assert property (o_phase[1] && o_instr_latch[15:9] == 7'h37 |-> o_dmem_addr == (o_instr_latch[8] ?
    {o_bank_selector[3:0], o_instr_latch[7:0]} : {(o_instr_latch[7:0] < 8'h60) ? 4'h0 : 4'hf, o_instr_latch[7:0]}))
    else $error("store address wrong");
  a_store_data: assert property (o_dmem_wr && o_instr_latch[15:9] == 7'h37 |-> o_dmem_wdata == o_work)
    else $error("store data wrong");
  a_bank_upper: assert property (o_bank_selector[7:4] == 4'h0)
    else $error("bank selector upper bits set");
  a_wr_impl: assert property (o_dmem_wr |-> IMPL_BANKS[o_dmem_addr[11:8]])
    else $error("write to unimplemented bank");
  a_flush_cycle: assert property ($rose(o_flush) |-> o_phase[0] ##0 o_flush[*4])
    else $error("discard not a whole cycle");
  a_flush_quiet: assert property (o_flush |-> o_instr_latch == 16'h0000 && !o_dmem_wr)
    else $error("discarded word has effect");
endmodule

bind cfp_core cfp_core_chk #(.IMPL_BANKS(IMPL_BANKS)) u_cfp_core_chk
(
  .i_clk(i_clk), .i_resetn(i_resetn), .o_phase(o_phase), .o_pmem_addr(o_pmem_addr), .o_pmem_rd(o_pmem_rd),
  .o_dmem_addr(o_dmem_addr), .o_dmem_rd(o_dmem_rd), .o_dmem_wr(o_dmem_wr), .o_dmem_wdata(o_dmem_wdata),
  .o_pc(o_pc), .o_instr_latch(o_instr_latch), .o_work(o_work), .o_bank_selector(o_bank_selector),
  .o_flush(o_flush)
);

// File: test/cfp_core_tb.sv
/*
  Self-checking bench of the pipeline core: small programs, results read back from data memory.
  Assumes the memory model and the bound checker.
*/
`timescale 1ns/1ps

module cfp_core_tb;
  typedef logic [15:0] cfp_prog_t [8];
  logic        i_clk;
  logic        i_resetn;
  logic [3:0]  o_phase;
  logic [20:0] o_pmem_addr;
  logic        o_pmem_rd;
  logic [15:0] pmem_data;
  logic [11:0] o_dmem_addr;
  logic        o_dmem_rd;
  logic [7:0]  dmem_rdata;
  logic        o_dmem_wr;
  logic [7:0]  o_dmem_wdata;
  logic [20:0] o_pc;
  logic [15:0] o_instr_latch;
  logic [7:0]  o_work;
  logic [7:0]  o_bank_selector;
  logic        o_flush;
  int          error_cnt;
  int          checked;
  int          flush_cnt;

  // bank 14 left unimplemented to see zero reads and dropped writes
  cfp_core #(.IMPL_BANKS(16'hbfff)) u_cfp_core
  (
    .i_clk(i_clk), .i_resetn(i_resetn), .o_phase(o_phase), .o_pmem_addr(o_pmem_addr), .o_pmem_rd(o_pmem_rd),
    .i_pmem_data(pmem_data), .o_dmem_addr(o_dmem_addr), .o_dmem_rd(o_dmem_rd), .i_dmem_rdata(dmem_rdata),
    .o_dmem_wr(o_dmem_wr), .o_dmem_wdata(o_dmem_wdata), .o_pc(o_pc), .o_instr_latch(o_instr_latch),
    .o_work(o_work), .o_bank_selector(o_bank_selector), .o_flush(o_flush)
  );

  cfp_mem_model u_cfp_mem_model
  (
    .i_clk(i_clk), .i_pmem_addr(o_pmem_addr), .o_pmem_data(pmem_data), .i_dmem_addr(o_dmem_addr),
    .i_dmem_rd(o_dmem_rd), .o_dmem_rdata(dmem_rdata), .i_dmem_wr(o_dmem_wr), .i_dmem_wdata(o_dmem_wdata)
  );

  always #2 i_clk = ~i_clk;

  always @(posedge i_clk)
  begin
    if (o_flush === 1'b1 && o_phase[0] === 1'b1)
      flush_cnt++;
  end

  task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // holds reset 8 clocks, loads the program and clears data memory
  task automatic load(input cfp_prog_t p);
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < 256; i++)
      u_cfp_mem_model.pmem[i] = (i < 8) ? p[i] : 16'h0000;
    for (int i = 0; i < 4096; i++)
      u_cfp_mem_model.dmem[i] = 8'h00;
    flush_cnt = 0;
  endtask

  task automatic go(input int cycles);
    i_resetn <= 1'b1;
    repeat (4 * cycles) @(posedge i_clk);
    #1;
  endtask

  function automatic logic [20:0] rd(input logic [11:0] a);
    return 21'(u_cfp_mem_model.dmem[a]);
  endfunction

  task automatic s_access();
    load('{16'h5010, 16'h6e20, 16'h0e55, 16'h6e80, 16'h0105, 16'h6f30, 16'h6f90, 16'h0000});
    u_cfp_mem_model.dmem[12'h010] = 8'ha5;
    go(10);
    check("read then store", 21'ha5, rd(12'h020));
    check("access high part", 21'h55, rd(12'hf80));
    check("banked low", 21'h55, rd(12'h530));
    check("banked high", 21'h55, rd(12'h590));
    check("bank selector", 21'h05, 21'(o_bank_selector));
    check("fetch address", 21'h14, o_pmem_addr);
    check("program counter", 21'h16, o_pc);
  endtask

  task automatic s_jump();
    load('{16'hef03, 16'hf000, 16'h6e41, 16'h0e22, 16'h6e40, 16'h0000, 16'h0000, 16'h0000});
    u_cfp_mem_model.dmem[12'h041] = 8'hff;
    go(10);
    check("word after jump", 21'hff, rd(12'h041));
    check("jump target", 21'h22, rd(12'h040));
    // the second word is consumed as the jump's literal, so no word is discarded
    check("jump discards", 21'h0, 21'(flush_cnt));
  endtask

  task automatic s_branch();
    load('{16'hd002, 16'h6e41, 16'h6e41, 16'h0e33, 16'h6e42, 16'h0000, 16'h0000, 16'h0000});
    u_cfp_mem_model.dmem[12'h041] = 8'hff;
    go(10);
    check("branched over", 21'hff, rd(12'h041));
    check("branch target", 21'h33, rd(12'h042));
    check("branch discards", 21'h1, 21'(flush_cnt));
  endtask

  task automatic s_skip(input logic [7:0] tested, input logic [7:0] exp_dst, input logic [20:0] exp_kill);
    load('{16'h6600, 16'hc123, 16'hf456, 16'h0e77, 16'h6e43, 16'h0000, 16'h0000, 16'h0000});
    u_cfp_mem_model.dmem[12'h000] = tested;
    u_cfp_mem_model.dmem[12'h123] = 8'h5c;
    u_cfp_mem_model.dmem[12'h456] = 8'haa;
    go(12);
    check("move destination", 21'(exp_dst), rd(12'h456));
    check("after move", 21'h77, rd(12'h043));
    check("skip discards", exp_kill, 21'(flush_cnt));
  endtask

  task automatic s_unimpl();
    load('{16'h010e, 16'h5110, 16'h6e44, 16'h6f20, 16'h0000, 16'h0000, 16'h0000, 16'h0000});
    u_cfp_mem_model.dmem[12'he10] = 8'h99;
    u_cfp_mem_model.dmem[12'h044] = 8'hff;
    u_cfp_mem_model.dmem[12'he20] = 8'h33;
    go(8);
    check("unimplemented read", 21'h00, rd(12'h044));
    check("unimplemented write", 21'h33, rd(12'he20));
    check("bank selector", 21'h0e, 21'(o_bank_selector));
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    error_cnt = 0;
    checked = 0;
    flush_cnt = 0;
    s_access();
    s_jump();
    s_branch();
    s_skip(8'h00, 8'haa, 21'h1);
    s_skip(8'h01, 8'h5c, 21'h0);
    s_unimpl();
    tally_and_finish();
  end

  // whole run is about 300 clocks
  initial
  begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
